// [design/vcad_pkg.sv]
// Purpose: shared constants for the video chip address decode block
// Assumes: 125 MHz clk, APB register access, 20-bit cpu address bus
// Notes: io ranges are eight-byte windows, except the sixteen-byte video window
package vcad_pkg;

	// self-test run length in clocks
	localparam int unsigned SELFTEST_CLOCKS = 4500;
	localparam int unsigned ROM_WORDS = 16;

	// io window bases
	localparam logic [15:0] IO_IRQ = 16'h0020;
	localparam logic [15:0] IO_TIMER = 16'h0040;
	localparam logic [15:0] IO_PIO = 16'h0060;
	localparam logic [15:0] IO_MASK = 16'h00A0;
	localparam logic [15:0] IO_SOUND = 16'h00C0;
	localparam logic [15:0] IO_GAME = 16'h0200;
	localparam logic [15:0] IO_PRINTER = 16'h0378;
	localparam logic [15:0] IO_FLOPPY = 16'h03F0;
	localparam logic [15:0] IO_VIDEO = 16'h03D0;

	// encoded select values
	localparam logic [2:0] SEL_NONE = 3'h7;
	localparam logic [2:0] SEL_IRQ = 3'h6;
	localparam logic [2:0] SEL_TIMER = 3'h5;
	localparam logic [2:0] SEL_PIO = 3'h4;
	localparam logic [2:0] SEL_GAME = 3'h3;
	localparam logic [2:0] SEL_SOUND = 3'h2;
	localparam logic [2:0] SEL_FLOPPY = 3'h1;
	localparam logic [2:0] SEL_PRINTER = 3'h0;

	// memory map
	localparam logic [19:0] LEN_128K = 20'h2_0000;
	localparam logic [19:0] LEN_256K = 20'h4_0000;
	localparam logic [4:0] VIDEO_WIN_TOP = 5'h17;
	localparam logic [3:0] ROM_TOP = 4'hF;

	// apb map
	localparam logic [11:0] ADDR_MEMCFG = 12'h000;
	localparam logic [11:0] ADDR_VIDMODE = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [5:0] MEMCFG_RESET = 6'h00;
	localparam logic [9:0] VIDMODE_RESET = 10'h000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_DONE = 2'b10
	} vcad_st_state_type;

endpackage

// [design/vcad_selftest_if.sv]
// Purpose: carrier between decode top and self-test engine
// Assumes: single clock domain
// Notes: start is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface vcad_selftest_if;
	logic start;
	logic busy;
	logic done;
	logic pass;
	modport engine (input start, output busy, output done, output pass);
	modport ctrl (output start, input busy, input done, input pass);
endinterface
`default_nettype wire

// [design/vcad_selftest.sv]
// Purpose: self-test rom signature engine
// Assumes: start pulse from the decode top
// Notes: xor signature over one rom sweep, held for the rest of the run
`timescale 1ns/1ns
`default_nettype none
module vcad_selftest #(
	parameter int unsigned RUN_CYCLES = vcad_pkg::SELFTEST_CLOCKS
) (
	input wire logic clk,
	input wire logic reset,
	vcad_selftest_if.engine st
);
	import vcad_pkg::*;

	// rom content closes to a zero signature; value set is arbitrary
	localparam logic [7:0] ROM [ROM_WORDS] = '{8'h12, 8'h34, 8'h56, 8'h78,
		8'h9A, 8'hBC, 8'hDE, 8'hF0, 8'h11, 8'h22, 8'h44, 8'h88, 8'h0F, 8'hF0,
		8'h5A, 8'h5A};

	vcad_st_state_type state_r, state_nxt;
	logic [12:0] count_r;
	logic [7:0] sig_r;
	logic lastCycle;
	logic inSweep;

	assign lastCycle = (count_r == 13'(RUN_CYCLES - 1));
	assign inSweep = (count_r < 13'(ROM_WORDS));
	assign st.busy = (state_r == ST_RUN);
	assign st.done = (state_r == ST_DONE);
	assign st.pass = st.done && (sig_r == 8'h00);

	// a new start restarts even a finished run
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: if (st.start) state_nxt = ST_RUN;
			ST_RUN: if (lastCycle) state_nxt = ST_DONE;
			ST_DONE: if (st.start) state_nxt = ST_RUN;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// run counter and signature
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			count_r <= '0;
			sig_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (st.start) begin
				count_r <= '0;
				sig_r <= '0;
			end else if (st.busy) begin
				count_r <= count_r + 13'd1;
				if (inSweep) sig_r <= sig_r ^ ROM[count_r[3:0]];
			end
		end
	end

endmodule
`default_nettype wire

// [design/vcad_decode.sv]
// Purpose: system address decode, video memory mapping and test modes
// Assumes: cpu pins are asynchronous and pass two flops before decode
// Notes: all pin outputs are registered, three edges after a cpu pin change, one edge after a video pin change
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module vcad_decode #(
	parameter int unsigned SELFTEST_RUN = vcad_pkg::SELFTEST_CLOCKS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [19:0] cpuAddr,
	input wire logic io_or_mem_qualifier,
	input wire logic cpu_mem_read_n,
	input wire logic cpu_mem_write_n,
	input wire logic cpuIoRead_n,
	input wire logic cpuIoWrite_n,
	input wire logic [14:0] crtAddr,
	input wire logic [1:0] raster_row,
	input wire logic coreHsync,
	input wire logic coreVsync,
	input wire logic videoGreen,
	input wire logic dramRowStrobe_n,
	input wire logic dramColStrobe_n,
	output logic [2:0] periphSelect,
	output logic board_buffer_enable_n,
	output logic bank0_write_en_n,
	output logic bank1_write_en_n,
	output logic row_strobe_n,
	output logic column_strobe_n,
	output logic [16:0] ram_addr,
	output logic hsync_out,
	output logic vsync_out,
	output logic green_video_out,
	output logic crtSoftReset,
	output logic clockGenClear,
	output logic forcedDisplayEnable
);
	import vcad_pkg::*;

	// two-flop synchronisers for every cpu pin
	logic [24:0] pinS1_r, pinS2_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pinS1_r <= {20'h0_0000, 5'h1F};
			pinS2_r <= {20'h0_0000, 5'h1F};
		end else begin
			pinS1_r <= {cpuAddr, io_or_mem_qualifier, cpu_mem_read_n, cpu_mem_write_n,
				cpuIoRead_n, cpuIoWrite_n};
			pinS2_r <= pinS1_r;
		end
	end

	logic [19:0] addr;
	logic memCycle, ioCycle, memRead, memWrite, ioStrobe;
	assign addr = pinS2_r[24:5];
	assign memCycle = pinS2_r[4];
	assign ioCycle = !pinS2_r[4];
	assign memRead = !pinS2_r[3];
	assign memWrite = !pinS2_r[2];
	assign ioStrobe = !pinS2_r[1] || !pinS2_r[0];

	// software registers
	logic [5:0] memCfg_r;
	logic [9:0] vidMode_r;
	logic [3:0] memConfig;
	logic external_video_disable, extended_addressing, graphics_select;
	logic video_addr_mode_lo, video_addr_mode_hi;
	logic [2:0] display_page_select, cpuPage;
	assign memConfig = memCfg_r[4:1];
	assign external_video_disable = memCfg_r[5];
	assign extended_addressing = vidMode_r[0];
	assign graphics_select = vidMode_r[1];
	assign video_addr_mode_lo = vidMode_r[2];
	assign video_addr_mode_hi = vidMode_r[3];
	assign display_page_select = vidMode_r[6:4];
	assign cpuPage = vidMode_r[9:7];

	// test mode entry, impossible in normal operation
	logic testActive, test1, test2, test3, test4;
	assign testActive = memRead && memWrite;
	assign test1 = testActive && addr[15];
	assign test2 = testActive && !addr[15] && addr[14];
	assign test3 = testActive && !addr[15] && addr[13];
	assign test4 = testActive && !addr[15];
	logic memAccess;
	assign memAccess = memCycle && (memRead ^ memWrite);

	// shared block placement; illegal codes map nothing
	logic [2:0] startCode;
	logic cfgValid;
	logic [19:0] sharedStart, sharedLen, sharedDiff;
	logic sharedHit;
	assign startCode = memConfig[3] ? memConfig[2:0] - 3'd1 : memConfig[2:0];
	assign cfgValid = memConfig[3] ? (memConfig[2:0] >= 3'd1 && memConfig[2:0] <= 3'd4)
		: (memConfig[2:0] <= 3'd4);
	assign sharedStart = {startCode, 17'h0_0000};
	assign sharedLen = memConfig[3] ? LEN_256K : LEN_128K;
	assign sharedDiff = addr - sharedStart;
	assign sharedHit = memAccess && cfgValid && (sharedDiff < sharedLen);

	// cpu window into video memory
	logic videoWinHit;
	logic [16:0] cpuVidOffset;
	assign videoWinHit = memAccess && (addr[19:15] == VIDEO_WIN_TOP) && !external_video_disable;
	assign cpuVidOffset = cpuPage[0] ? {cpuPage, addr[13:0]} : {cpuPage[2:1], addr[14:0]};

	// display address by organisation
	logic modeLo;
	logic [16:0] displayAddr;
	assign modeLo = video_addr_mode_lo || graphics_select;
	always_comb begin
		displayAddr = {display_page_select, crtAddr[13:0]};
		if (!extended_addressing) begin
			unique case ({video_addr_mode_hi, modeLo})
				2'b00: displayAddr = {display_page_select, crtAddr[13:0]};
				2'b01: displayAddr = {display_page_select, raster_row[0], crtAddr[12:0]};
				2'b10: displayAddr = {display_page_select[2:1], raster_row[0], crtAddr[13:0]};
				2'b11: displayAddr = {display_page_select[2:1], raster_row, crtAddr[12:0]};
			endcase
		end else if (modeLo) begin
			displayAddr = {display_page_select[2], raster_row[0], crtAddr[14:0]};
		end else begin
			displayAddr = {display_page_select[2:1], crtAddr[14:0]};
		end
	end

	// io decode on 16-bit io address
	logic hitIrq, hitTimer, hitPio, hitMask, hitSound, hitGame, hitPrn, hitFdc;
	logic hitVidIo, vidIoBlocked;
	assign hitIrq = ioCycle && (addr[15:3] == IO_IRQ[15:3]);
	assign hitTimer = ioCycle && (addr[15:3] == IO_TIMER[15:3]);
	assign hitPio = ioCycle && (addr[15:3] == IO_PIO[15:3]);
	assign hitMask = ioCycle && (addr[15:3] == IO_MASK[15:3]);
	assign hitSound = ioCycle && (addr[15:3] == IO_SOUND[15:3]);
	assign hitGame = ioCycle && (addr[15:3] == IO_GAME[15:3]);
	assign hitPrn = ioCycle && (addr[15:3] == IO_PRINTER[15:3]);
	assign hitFdc = ioCycle && (addr[15:3] == IO_FLOPPY[15:3]);
	assign vidIoBlocked = external_video_disable && !addr[3];
	assign hitVidIo = ioCycle && (addr[15:4] == IO_VIDEO[15:4]) && !vidIoBlocked;

	// encoded select, address and io qualifier only; the external decoder adds strobes
	logic [2:0] selNxt;
	always_comb begin
		selNxt = SEL_NONE;
		if (hitIrq) selNxt = SEL_IRQ;
		else if (hitTimer) selNxt = SEL_TIMER;
		else if (hitPio) selNxt = SEL_PIO;
		else if (hitGame) selNxt = SEL_GAME;
		else if (hitSound) selNxt = SEL_SOUND;
		else if (hitFdc) selNxt = SEL_FLOPPY;
		else if (hitPrn) selNxt = SEL_PRINTER;
	end

	// buffer enable terms
	logic romHit, boardIo, bufNxt;
	assign romHit = memAccess && (addr[19:16] == ROM_TOP);
	assign boardIo = ioStrobe && (hitTimer || hitPio || hitMask || hitSound || hitGame ||
		hitPrn || hitFdc || hitVidIo);
	assign bufNxt = !(sharedHit || videoWinHit || romHit || boardIo);

	// ram port: cpu wins over display fetch, low bit picks the bank
	logic cpuRam;
	logic [17:0] cpuOffset;
	logic [16:0] ramAddrNxt;
	assign cpuRam = sharedHit || videoWinHit;
	assign cpuOffset = sharedHit ? sharedDiff[17:0] : {1'b0, cpuVidOffset};
	assign ramAddrNxt = cpuRam ? cpuOffset[17:1] : displayAddr;

	// self-test engine
	vcad_selftest_if stIf ();
	logic test1_r;
	assign stIf.start = test1 && !test1_r;
	vcad_selftest #(
		.RUN_CYCLES(SELFTEST_RUN)
	) u_selftest (
		.clk(clk),
		.reset(reset),
		.st(stIf)
	);

	// registered pin outputs, inactive in reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			periphSelect <= SEL_NONE;
			board_buffer_enable_n <= 1'b1;
			bank0_write_en_n <= 1'b1;
			bank1_write_en_n <= 1'b1;
			ram_addr <= '0;
		end else begin
			periphSelect <= selNxt;
			board_buffer_enable_n <= bufNxt;
			bank0_write_en_n <= !(cpuRam && memWrite && !cpuOffset[0]);
			bank1_write_en_n <= !(cpuRam && memWrite && cpuOffset[0]);
			ram_addr <= ramAddrNxt;
		end
	end

	// test outputs; core pins only swapped while mode one holds
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			test1_r <= 1'b0;
			crtSoftReset <= 1'b0;
			clockGenClear <= 1'b0;
			forcedDisplayEnable <= 1'b0;
			row_strobe_n <= 1'b1;
			column_strobe_n <= 1'b1;
			hsync_out <= 1'b0;
			vsync_out <= 1'b0;
			green_video_out <= 1'b0;
		end else begin
			test1_r <= test1;
			crtSoftReset <= test2;
			clockGenClear <= test3;
			if (test4) forcedDisplayEnable <= addr[12];
			row_strobe_n <= test1 ? raster_row[0] : dramRowStrobe_n;
			column_strobe_n <= test1 ? raster_row[1] : dramColStrobe_n;
			hsync_out <= coreHsync;
			vsync_out <= coreVsync;
			green_video_out <= test1 ? stIf.pass : videoGreen;
		end
	end

	// apb slave, zero wait; unmapped gives pslverr, no write
	logic apbWrite, hitMemCfg, hitVidMode, hitStatus, mapped;
	assign hitMemCfg = (paddr == ADDR_MEMCFG);
	assign hitVidMode = (paddr == ADDR_VIDMODE);
	assign hitStatus = (paddr == ADDR_STATUS);
	assign mapped = hitMemCfg || hitVidMode || hitStatus;
	assign apbWrite = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	always_comb begin
		prdata = 32'h0000_0000;
		if (hitMemCfg) prdata = {26'h0, memCfg_r};
		else if (hitVidMode) prdata = {22'h0, vidMode_r};
		else if (hitStatus) prdata = {27'h0, testActive, forcedDisplayEnable, stIf.pass,
			stIf.done, test1_r};
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			memCfg_r <= MEMCFG_RESET;
			vidMode_r <= VIDMODE_RESET;
		end else begin
			if (apbWrite && hitMemCfg) memCfg_r <= {pwdata[5:1], 1'b0};
			if (apbWrite && hitVidMode) vidMode_r <= pwdata[9:0];
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_sel_irq;
		ioCycle && addr[15:3] == 13'h0004 |=> periphSelect == 3'b110;
	endproperty
	a_sel_irq: assert property (p_sel_irq) else $error("irq select code wrong");

	property p_sel_none;
		memCycle |=> periphSelect == 3'b111;
	endproperty
	a_sel_none: assert property (p_sel_none) else $error("select not idle on memory");

	property p_sel_prn;
		ioCycle && addr[15:3] == 13'h006F |=> periphSelect == 3'b000;
	endproperty
	a_sel_prn: assert property (p_sel_prn) else $error("printer select code wrong");

	property p_buf_rom;
		memCycle && (memRead ^ memWrite) && addr[19:16] == 4'hF |=> !board_buffer_enable_n;
	endproperty
	a_buf_rom: assert property (p_buf_rom) else $error("rom access without buffer");

	property p_buf_mask;
		ioCycle && ioStrobe && addr[15:3] == 13'h0014 |=> !board_buffer_enable_n;
	endproperty
	a_buf_mask: assert property (p_buf_mask) else $error("mask io without buffer");

	property p_vid_block;
		external_video_disable && memCycle && addr[19:15] == 5'h17 |=> board_buffer_enable_n;
	endproperty
	a_vid_block: assert property (p_vid_block) else $error("blocked video buffered");

	property p_shared_256;
		memConfig == 4'h9 && memCycle && memRead && !memWrite && addr[19:18] == 2'b00
			|=> !board_buffer_enable_n;
	endproperty
	a_shared_256: assert property (p_shared_256) else $error("256K block missed");

	property p_fde;
		test4 |=> forcedDisplayEnable == $past(addr[12]) ##1 forcedDisplayEnable ||
			$past(test4) || !$past(forcedDisplayEnable);
	endproperty
	a_fde: assert property (p_fde) else $error("forced display bit wrong");

	property p_test2;
		memRead && memWrite && !addr[15] && addr[14] |=> crtSoftReset;
	endproperty
	a_test2: assert property (p_test2) else $error("core reset missing");

	property p_row_route;
		test1 |=> row_strobe_n == $past(raster_row[0]) && column_strobe_n == $past(raster_row[1]);
	endproperty
	a_row_route: assert property (p_row_route) else $error("core raster not routed");

	property p_green;
		test1 && stIf.done |=> green_video_out == $past(stIf.pass);
	endproperty
	a_green: assert property (p_green) else $error("pass bit not on green");

	c_test1_done: cover property (test1 && stIf.done);
	c_shared_write: cover property (sharedHit && memWrite ##1 !bank1_write_en_n);
	c_floppy: cover property (periphSelect == 3'b001);

endmodule
`default_nettype wire

// [verification/vcad_cpu_model.sv]
// Purpose: cpu side bus model driving address, qualifier and strobes
// Assumes: callers enter its tasks right after a rising clock edge
// Notes: a released address bus shows the inverse of its last value
`timescale 1ns/1ns
`default_nettype none
module vcad_cpu_model (
	output logic [19:0] cpuAddr,
	output logic io_or_mem_qualifier,
	output logic cpu_mem_read_n,
	output logic cpu_mem_write_n,
	output logic cpuIoRead_n,
	output logic cpuIoWrite_n
);
	// idle bus at time zero, all strobes inactive
	initial begin
		cpuAddr = 20'h0_0000;
		io_or_mem_qualifier = 1'b1;
		{cpu_mem_read_n, cpu_mem_write_n, cpuIoRead_n, cpuIoWrite_n} = 4'hF;
	end

	// one bus cycle; strobe order is mem read, mem write, io read, io write
	// both memory strobes low only when asked
	task automatic drive(input logic [19:0] a, input logic isMem, input logic [3:0] strobeN);
		cpuAddr <= a;
		io_or_mem_qualifier <= isMem;
		{cpu_mem_read_n, cpu_mem_write_n, cpuIoRead_n, cpuIoWrite_n} <= strobeN;
	endtask

	// a released bus has no keeper, so never leave the old address showing
	task automatic freeBus();
		cpuAddr <= ~cpuAddr;
		io_or_mem_qualifier <= 1'b1;
		{cpu_mem_read_n, cpu_mem_write_n, cpuIoRead_n, cpuIoWrite_n} <= 4'hF;
	endtask
endmodule
`default_nettype wire

// [verification/video_chip_address_decode_bench.sv]
// Purpose: self-checking bench for the address decode block
// Assumes: outputs settle three edges after a cpu pin change, one edge after a video pin change, apb answers at once
// Notes: self-test length shortened to 40 clocks
`timescale 1ns/1ns
`default_nettype none
module video_chip_address_decode_bench;
	import vcad_pkg::*;
	typedef struct {logic isMem; logic [19:0] addr; logic [2:0] sel; logic bufN;} vcad_row_type;
	localparam int unsigned RUN = 40;
	logic clk, reset, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err;
	logic [19:0] cpuAddr;
	logic io_or_mem_qualifier, cpu_mem_read_n, cpu_mem_write_n, cpuIoRead_n, cpuIoWrite_n;
	logic [14:0] crtAddr;
	logic [1:0] raster_row;
	logic coreHsync, coreVsync, videoGreen, dramRowStrobe_n, dramColStrobe_n;
	logic [2:0] periphSelect;
	logic board_buffer_enable_n, bank0_write_en_n, bank1_write_en_n, row_strobe_n, column_strobe_n;
	logic [16:0] ram_addr;
	logic hsync_out, vsync_out, green_video_out, crtSoftReset, clockGenClear, forcedDisplayEnable;
	int bad_count = 0;
	int check_count = 0;
	vcad_row_type rows[$];

	vcad_decode #(.SELFTEST_RUN(RUN)) dut_u (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpuAddr(cpuAddr),
		.io_or_mem_qualifier(io_or_mem_qualifier), .cpu_mem_read_n(cpu_mem_read_n),
		.cpu_mem_write_n(cpu_mem_write_n), .cpuIoRead_n(cpuIoRead_n), .cpuIoWrite_n(cpuIoWrite_n),
		.crtAddr(crtAddr), .raster_row(raster_row), .coreHsync(coreHsync), .coreVsync(coreVsync),
		.videoGreen(videoGreen), .dramRowStrobe_n(dramRowStrobe_n),
		.dramColStrobe_n(dramColStrobe_n), .periphSelect(periphSelect),
		.board_buffer_enable_n(board_buffer_enable_n), .bank0_write_en_n(bank0_write_en_n),
		.bank1_write_en_n(bank1_write_en_n), .row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n), .ram_addr(ram_addr), .hsync_out(hsync_out),
		.vsync_out(vsync_out), .green_video_out(green_video_out), .crtSoftReset(crtSoftReset),
		.clockGenClear(clockGenClear), .forcedDisplayEnable(forcedDisplayEnable));

	vcad_cpu_model cpu_u (.cpuAddr(cpuAddr), .io_or_mem_qualifier(io_or_mem_qualifier),
		.cpu_mem_read_n(cpu_mem_read_n), .cpu_mem_write_n(cpu_mem_write_n),
		.cpuIoRead_n(cpuIoRead_n), .cpuIoWrite_n(cpuIoWrite_n));

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask

	// apb transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			summarize();
		end
	endtask

	// wait past the two synchroniser flops and the output register
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic cyc(input logic [19:0] a, input logic isMem, input logic [3:0] strobeN);
		@(posedge clk);
		cpu_u.drive(a, isMem, strobeN);
		settle();
	endtask

	task automatic idle();
		@(posedge clk);
		cpu_u.freeBus();
		settle();
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		summarize();
	end

	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		{crtAddr, raster_row, coreHsync, coreVsync} = 19'h0_0000;
		{videoGreen, dramRowStrobe_n, dramColStrobe_n} = 3'b011;
		rows.push_back('{1'b0, 20'h0_0020, 3'h6, 1'b1});
		rows.push_back('{1'b0, 20'h0_0027, 3'h6, 1'b1});
		rows.push_back('{1'b0, 20'h0_0028, 3'h7, 1'b1});
		rows.push_back('{1'b0, 20'h0_0040, 3'h5, 1'b0});
		rows.push_back('{1'b0, 20'h0_0060, 3'h4, 1'b0});
		rows.push_back('{1'b0, 20'h0_0200, 3'h3, 1'b0});
		rows.push_back('{1'b0, 20'h0_00C0, 3'h2, 1'b0});
		rows.push_back('{1'b0, 20'h0_03F7, 3'h1, 1'b0});
		rows.push_back('{1'b0, 20'h0_037F, 3'h0, 1'b0});
		rows.push_back('{1'b0, 20'h0_00A0, 3'h7, 1'b0});
		rows.push_back('{1'b0, 20'h0_03DF, 3'h7, 1'b0});
		rows.push_back('{1'b0, 20'h0_0100, 3'h7, 1'b1});
		rows.push_back('{1'b1, 20'h2_0000, 3'h7, 1'b0});
		rows.push_back('{1'b1, 20'h3_FFFF, 3'h7, 1'b0});
		rows.push_back('{1'b1, 20'h1_FFFF, 3'h7, 1'b1});
		rows.push_back('{1'b1, 20'hB_8000, 3'h7, 1'b0});
		rows.push_back('{1'b1, 20'hF_0000, 3'h7, 1'b0});
		rows.push_back('{1'b1, 20'hC_0000, 3'h7, 1'b1});
		repeat (20) @(posedge clk);
		#1;
		chk("select in reset", 32'h7, periphSelect);
		chk("buffer in reset", 32'h1, board_buffer_enable_n);
		@(posedge clk);
		reset <= 1'b0;
		// register access, bit 0 of the config reads zero, unmapped place refused
		apb(1'b1, ADDR_MEMCFG, 32'h0000_0003);
		apb(1'b0, ADDR_MEMCFG, 32'h0000_0000);
		chk("memcfg", 32'h0000_0002, rd);
		apb(1'b1, ADDR_VIDMODE, 32'hFFFF_FFFF);
		apb(1'b0, ADDR_VIDMODE, 32'h0000_0000);
		chk("vidmode", 32'h0000_03FF, rd);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk("unmapped err", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		// table of io and memory decodes, 128K shared block at 20000
		foreach (rows[i]) begin
			cyc(rows[i].addr, rows[i].isMem, rows[i].isMem ? 4'b0111 : 4'b1101);
			chk("periphSelect", {29'h0, rows[i].sel}, periphSelect);
			chk("buffer", {31'h0, rows[i].bufN}, board_buffer_enable_n);
			idle();
		end
		// odd cpu page gives a 16K window, word address is offset over two
		cyc(20'hB_8002, 1'b1, 4'b0111);
		chk("cpu window", 32'hE001, ram_addr);
		// 256K block at 00000
		apb(1'b1, ADDR_MEMCFG, 32'h0000_0012);
		cyc(20'h3_FFFF, 1'b1, 4'b0111);
		chk("256k code one", 32'h0, board_buffer_enable_n);
		// 256K block at 20000
		apb(1'b1, ADDR_MEMCFG, 32'h0000_0014);
		cyc(20'h5_FFFF, 1'b1, 4'b0111);
		chk("256k top", 32'h0, board_buffer_enable_n);
		cyc(20'h6_0000, 1'b1, 4'b0111);
		chk("256k past", 32'h1, board_buffer_enable_n);
		// external video disable
		apb(1'b1, ADDR_MEMCFG, 32'h0000_0022);
		cyc(20'hB_8000, 1'b1, 4'b0111);
		chk("video mem blocked", 32'h1, board_buffer_enable_n);
		cyc(20'h0_03D0, 1'b0, 4'b1101);
		chk("video io blocked", 32'h1, board_buffer_enable_n);
		cyc(20'h0_03D8, 1'b0, 4'b1101);
		chk("video io upper", 32'h0, board_buffer_enable_n);
		// bank write enables by offset parity
		apb(1'b1, ADDR_MEMCFG, 32'h0000_0002);
		cyc(20'h2_0006, 1'b1, 4'b1011);
		chk("bank0 even", 32'h2, {bank1_write_en_n, bank0_write_en_n});
		chk("bank word", 32'h3, ram_addr);
		cyc(20'h2_0007, 1'b1, 4'b1011);
		chk("bank1 odd", 32'h1, {bank1_write_en_n, bank0_write_en_n});
		// test modes two, three, four
		cyc(20'h0_4000, 1'b1, 4'b0011);
		chk("soft reset", 32'h2, {crtSoftReset, clockGenClear});
		cyc(20'h0_2000, 1'b1, 4'b0011);
		chk("clock clear", 32'h1, {crtSoftReset, clockGenClear});
		cyc(20'h2_1000, 1'b1, 4'b0011);
		chk("forced set", 32'h1, forcedDisplayEnable);
		chk("test no buffer", 32'h1, board_buffer_enable_n);
		cyc(20'h2_1000, 1'b1, 4'b0111);
		chk("forced held", 32'h1, forcedDisplayEnable);
		chk("one strobe shared", 32'h0, board_buffer_enable_n);
		cyc(20'h2_0000, 1'b1, 4'b0011);
		chk("forced cleared", 32'h0, forcedDisplayEnable);
		idle();
		// normal mode pass-through of row strobe, syncs and green
		@(posedge clk);
		{videoGreen, dramRowStrobe_n, coreHsync, coreVsync, crtAddr} <= {4'b1011, 15'h3234};
		settle();
		chk("normal pins", 32'hB, {green_video_out, row_strobe_n, hsync_out, vsync_out});
		// idle bus puts the display fetch on the ram address
		chk("display extended", 32'h1_3234, ram_addr);
		// graphics select alone must act as mode 01: bit 13 replaced by raster bit
		apb(1'b1, ADDR_VIDMODE, 32'h0000_0052);
		settle();
		chk("display graphics", 32'h1_5234, ram_addr);
		// test mode one, raster bits on the strobe pins, pass bit after the run
		@(posedge clk);
		{videoGreen, raster_row} <= 3'b010;
		cyc(20'h0_8000, 1'b1, 4'b0011);
		chk("raster on strobes", 32'h2, {column_strobe_n, row_strobe_n});
		chk("pass early", 32'h0, green_video_out);
		// tester waits the full run before sampling
		for (int k = 0; k < RUN + 8; k++) begin
			@(posedge clk);
			// qualifier toggled on every rising clock edge, test mode must hold
			cpu_u.drive(20'h0_8000, k[0], 4'b0011);
		end
		#1;
		chk("pass on green", 32'h1, green_video_out);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk("status", 32'h17, {27'h0, rd[4:0]});
		// mid-run reset clears the sticky bit and outputs
		cyc(20'h0_1000, 1'b1, 4'b0011);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("reset state", 32'h78, {forcedDisplayEnable, periphSelect, board_buffer_enable_n,
			crtSoftReset, clockGenClear, green_video_out});
		@(posedge clk);
		reset <= 1'b0;
		idle();
		// pins still held in mode four at release, so the bit comes back
		chk("forced after reset", 32'h1, forcedDisplayEnable);
		summarize();
	end
endmodule
`default_nettype wire
